// file: include/rw_channel_pkg.sv
/*
 * Constants, types and packed carriers for the read/write channel control.
 * Assumes a single 10 MHz reference clock and an AHB-Lite register bus.
 */
package rw_channel_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_HZ           = 10_000_000;
    localparam int POR_HOLD_MS      = 100;
    localparam int POR_HOLD_CYC     = POR_HOLD_MS * (CLK_HZ / 1000);
    localparam int NOISE_GATE_NS    = 200;
    localparam int NOISE_GATE_CYC   =
        (NOISE_GATE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SELFTEST_US      = 1000;
    localparam int SELFTEST_CYC     = SELFTEST_US * (CLK_HZ / 1_000_000);

    // ==========================================================
    // Heads and zones
    // ==========================================================
    localparam logic [3:0]  HEADS_PER_PREAMP = 4'h4;
    localparam logic [15:0] INNER_ZONE_LIMIT = 16'h0200;
    // Synchroniser reset: active-low controls idle high, so no false
    // select or write gate is seen in the first cycles after reset
    localparam logic [14:0] SYNC_IDLE = 15'h7E00;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] TRACK_ADDR  = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] COUNT_ADDR  = 8'h0C;

    // Control register field positions
    localparam int CTRL_SEVEN_HEAD = 0;
    localparam int CTRL_FAULT_CLR  = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic       lowEnableN;
        logic       highEnableN;
        logic       bitA;
        logic       bitB;
        logic       writeEnable;
    } preamp_sel_t;

    typedef struct packed {
        logic spindleBad;
        logic offTrack;
        logic preampUnsafe;
        logic currentBad;
    } health_t;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_TEST  = 3'b010,
        ST_READY = 3'b100
    } drive_state_t;

endpackage : rw_channel_pkg

// file: rtl/disk_rw_channel_control.sv
/*
 * Read/write channel control: head decode, read pulse gating, write
 * transition generation, write current control, write fault, self test
 * and supply-valid reset holding, with an AHB-Lite register slave.
 * Assumes every pin input except the AHB-Lite bus and selfTestPass is asynchronous to ref_clk; analog blocks
 * outside deliver comparator levels (zero cross, supplies, health).
 */
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// - Decode head selects and write gate into chip enables, head bits, write enable.
// - Highest-weight head select line is ignored in decoding.
// - Seven-head mode: low enable for heads 0-3, high enable heads 4-6.
// - Head bits and write enable are shared by both preamplifiers.
// - One read pulse per read signal peak forwarded to controller.
// - Read pulses are blocked while write enable is active.
// - Zero-crossing output is gated to suppress noise pulses.
// - Write input becomes one rising pulse per transition to record.
// - Each write pulse toggles the write current direction level.
// - Write current and write control active only with write gate.
// - During writing, an abnormal condition asserts active-low write fault.
// - Fault inputs: preamp unsafe, current source status, head select status.
// - After power-on self test, ready and seek complete assert.
// - Spindle or off-track limits drop ready and seek complete.
// - Reset holds until all three supplies are valid.
// - Any supply drop reasserts reset and stops operation.
// - Seek complete falling with write gate raises fault, kills writing.
// - All head selects inactive selects head zero; binary weighting.
module disk_rw_channel_control
    import rw_channel_pkg::*;
#(
    parameter int PorHoldCycles  = POR_HOLD_CYC,
    parameter int SelfTestCycles = SELFTEST_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Host interface pins
    input  wire logic        drive_select_n,
    input  wire logic        head_sel_bit0_n,
    input  wire logic        head_sel_bit1_n,
    input  wire logic        head_sel_bit2_n,
    input  wire logic        head_sel_bit3_n,
    input  wire logic        writeGateN,
    input  wire logic        write_pulse_pair,
    output logic             read_pulse_pair,
    output logic             write_fault_n,
    output logic             readyN,
    output logic             seek_complete_n,
    // Preamplifier side
    output logic             preamp_low_enable_n,
    output logic             preamp_high_enable_n,
    output logic             head_bit_a,
    output logic             head_bit_b,
    output logic             write_enable_out,
    output logic             write_control_out,
    output logic             writeCurrentHigh,
    input  wire logic        preamp_unsafe,
    input  wire logic        zeroCross,
    // Supply and mechanics monitors
    input  wire logic        supply5Ok,
    input  wire logic        supply12Ok,
    input  wire logic        supplyNeg10Ok,
    input  wire logic        spindleBad,
    input  wire logic        offTrack,
    input  wire logic        currentSourceBad,
    input  wire logic        selfTestPass
);
    default clocking defClk @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    localparam int NSYNC = 15;
    logic [NSYNC-1:0] syncA_q;
    logic [NSYNC-1:0] syncB_q;
    wire  [NSYNC-1:0] rawIn = {drive_select_n, head_sel_bit0_n,
        head_sel_bit1_n, head_sel_bit2_n, head_sel_bit3_n, writeGateN,
        write_pulse_pair, preamp_unsafe, zeroCross, supply5Ok, supply12Ok,
        supplyNeg10Ok, spindleBad, offTrack, currentSourceBad};

    // Two stages; only the second stage is read by logic
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            syncA_q <= SYNC_IDLE;
            syncB_q <= SYNC_IDLE;
        end else begin
            syncA_q <= rawIn;
            syncB_q <= syncA_q;
        end
    end

    wire dsN   = syncB_q[14];
    wire hs0N  = syncB_q[13];
    wire hs1N  = syncB_q[12];
    wire hs2N  = syncB_q[11];
    wire wgN   = syncB_q[9];
    wire wPin  = syncB_q[8];
    wire zcIn  = syncB_q[6];
    wire supOk = syncB_q[5] & syncB_q[4] & syncB_q[3];
    health_t health;
    assign health = '{spindleBad: syncB_q[2], offTrack: syncB_q[1],
                      preampUnsafe: syncB_q[7], currentBad: syncB_q[0]};
    wire selfPass = selfTestPass; // Same-domain strobe from test logic

    // ==========================================================
    // Power-on reset hold
    // ==========================================================
    logic [31:0] porCnt_q;
    logic        porActive_q;
    // Any supply drop restarts the hold
    wire porDone = (porCnt_q >= 32'(PorHoldCycles));
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            porCnt_q    <= '0;
            porActive_q <= 1'b1;
        end else if (!supOk) begin
            porCnt_q    <= '0;
            porActive_q <= 1'b1;
        end else begin
            porCnt_q    <= porDone ? porCnt_q : porCnt_q + 32'd1;
            porActive_q <= !porDone;
        end
    end

    // ==========================================================
    // Registers over AHB-Lite
    // ==========================================================
    logic        sevenHead_q;
    logic [15:0] track_q;
    logic [15:0] pulseCnt_q;
    logic        apWrite_q;
    logic [7:0]  apAddr_q;
    wire apValid = hsel && hready && (htrans == HTRANS_NONSEQ);

    // Address phase capture, data phase always zero wait
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            apWrite_q <= 1'b0;
            apAddr_q  <= '0;
        end else begin
            apWrite_q <= apValid && hwrite;
            apAddr_q  <= haddr[7:0];
        end
    end

    wire ctrlWr  = apWrite_q && (apAddr_q == CTRL_ADDR);
    wire trackWr = apWrite_q && (apAddr_q == TRACK_ADDR);
    wire faultClr = ctrlWr && hwdata[CTRL_FAULT_CLR];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sevenHead_q <= CTRL_RESET[CTRL_SEVEN_HEAD];
            track_q     <= '0;
        end else begin
            if (ctrlWr)
                sevenHead_q <= hwdata[CTRL_SEVEN_HEAD];
            if (trackWr)
                track_q <= hwdata[15:0];
        end
    end

    drive_state_t state_q;
    logic         wFault_q;
    logic [31:0]  statusWord;
    assign statusWord = {24'h0, 2'h0, state_q, wFault_q,
                         porActive_q, write_enable_out};

    // Launched at the address edge; unmapped reads zero, always OKAY
    wire [31:0] rdMux =
        (haddr[7:0] == CTRL_ADDR)   ? {31'h0, sevenHead_q} :
        (haddr[7:0] == TRACK_ADDR)  ? {16'h0, track_q} :
        (haddr[7:0] == STATUS_ADDR) ? statusWord :
        (haddr[7:0] == COUNT_ADDR)  ? {16'h0, pulseCnt_q} : 32'h0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= (apValid && !hwrite) ? rdMux : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ==========================================================
    // Self test and readiness
    // ==========================================================
    logic [31:0] testCnt_q;
    wire healthBad = health.spindleBad || health.offTrack;
    wire testDone  = selfPass || (testCnt_q >= 32'(SelfTestCycles));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q   <= ST_RESET;
            testCnt_q <= '0;
        end else if (porActive_q) begin
            state_q   <= ST_RESET;
            testCnt_q <= '0;
        end else begin
            case (state_q)
                ST_RESET: state_q <= ST_TEST;
                ST_TEST: begin
                    testCnt_q <= testCnt_q + 32'd1;
                    if (testDone && !healthBad)
                        state_q <= ST_READY;
                end
                ST_READY: if (healthBad) begin
                    state_q   <= ST_TEST;
                    testCnt_q <= '0;
                end
                default: state_q <= ST_RESET;
            endcase
        end
    end

    wire ready = (state_q == ST_READY);

    // ==========================================================
    // Head decode and write gating
    // ==========================================================
    // Control lines act only while drive select is low
    wire selected = !dsN;
    wire [2:0] headNum = selected ? {~hs2N, ~hs1N, ~hs0N} : 3'h0;
    // Top select line deliberately left out of the decode
    wire highHead  = sevenHead_q && (headNum >= 3'(HEADS_PER_PREAMP));
    wire writeReq  = selected && !wgN && ready && !porActive_q;
    wire headBadSt = !sevenHead_q && headNum[2];
    logic wgDrop;
    assign wgDrop = selected && !wgN && !ready;

    preamp_sel_t sel_d;
    assign sel_d = '{lowEnableN: highHead, highEnableN: !highHead,
                     bitA: headNum[0], bitB: headNum[1],
                     writeEnable: writeReq && !wFault_q};

    // Decoded selection, shared head bits to both preamps
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            preamp_low_enable_n  <= 1'b1;
            preamp_high_enable_n <= 1'b1;
            head_bit_a           <= 1'b0;
            head_bit_b           <= 1'b0;
            write_enable_out     <= 1'b0;
        end else begin
            preamp_low_enable_n  <= porActive_q | sel_d.lowEnableN;
            preamp_high_enable_n <= porActive_q | sel_d.highEnableN;
            head_bit_a           <= sel_d.bitA;
            head_bit_b           <= sel_d.bitB;
            write_enable_out     <= sel_d.writeEnable;
        end
    end

    // ==========================================================
    // Write chain
    // ==========================================================
    logic wPinD_q;
    logic dirLevel_q;
    wire  wPulse = wPin && !wPinD_q; // One pulse per transition

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wPinD_q           <= 1'b0;
            dirLevel_q        <= 1'b0;
            write_control_out <= 1'b0;
            writeCurrentHigh  <= 1'b0;
        end else begin
            wPinD_q <= wPin;
            if (wPulse && write_enable_out)
                dirLevel_q <= !dirLevel_q; // Divide by two
            // Current only while gated write is on
            write_control_out <= sel_d.writeEnable && dirLevel_q;
            writeCurrentHigh  <= sel_d.writeEnable &&
                                 (track_q < INNER_ZONE_LIMIT);
        end
    end
    por_write_off_a: assert property (porActive_q |=>
        !write_enable_out && !write_control_out) else $error("write in hold");
    toggle_dir_a: assert property (wPulse && write_enable_out |=>
        $changed(dirLevel_q)) else $error("write direction did not toggle");

    // ==========================================================
    // Write fault
    // ==========================================================
    wire faultCause = (write_enable_out && (health.preampUnsafe ||
        health.currentBad || headBadSt)) || wgDrop;

    // Sticky; a new cause in the clear cycle wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wFault_q      <= 1'b0;
            write_fault_n <= 1'b1;
        end else begin
            wFault_q      <= faultCause | (wFault_q & !faultClr);
            write_fault_n <= !(faultCause | (wFault_q & !faultClr));
        end
    end
    sequence faultThenOff;
        !write_fault_n ##1 !write_enable_out;
    endsequence
    fault_stop_a: assert property (faultCause |=> faultThenOff)
        else $error("fault did not stop the write");

    // ==========================================================
    // Read chain
    // ==========================================================
    // Noise gate: a zero-cross level must hold before it counts,
    // trading a little latency for immunity to short glitches.
    logic [7:0] gateCnt_q;
    logic       zcStable_q;
    logic       zcPrev_q;
    wire  gateDone = (gateCnt_q >= 8'(NOISE_GATE_CYC));
    wire  peak     = gateDone && (zcIn == zcPrev_q) && (zcIn != zcStable_q);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gateCnt_q       <= '0;
            zcStable_q      <= 1'b0;
            zcPrev_q        <= 1'b0;
            read_pulse_pair <= 1'b0;
            pulseCnt_q      <= '0;
        end else begin
            zcPrev_q  <= zcIn;
            gateCnt_q <= (zcIn != zcPrev_q) ? 8'h0 :
                         (gateDone ? gateCnt_q : gateCnt_q + 8'h1);
            if (peak)
                zcStable_q <= zcIn;
            // One pulse per peak, silent while writing
            read_pulse_pair <= peak && !write_enable_out && !porActive_q;
            if (peak && !write_enable_out)
                pulseCnt_q <= pulseCnt_q + 16'h1;
        end
    end
    read_quiet_a: assert property (write_enable_out |=>
        !read_pulse_pair) else $error("read pulse while writing");
    pulse_once_a: assert property (read_pulse_pair |=>
        !read_pulse_pair) else $error("read pulse held too long");

    // ==========================================================
    // Host status lines
    // ==========================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            readyN          <= 1'b1;
            seek_complete_n <= 1'b1;
        end else begin
            readyN          <= !(ready && !healthBad);
            seek_complete_n <= !(ready && !healthBad);
        end
    end
    health_drop_a: assert property (healthBad |=> readyN &&
        seek_complete_n) else $error("ready held with bad health");

endmodule : disk_rw_channel_control

// file: verif/host_ctrl_model.sv
/*
 * Host disc controller model: drives select, head, write gate and
 * write data pins of the drive. Assumes the bench steers it through
 * plain request inputs sampled on the rising edge of ref_clk.
 */
`timescale 1ns/1ps
module host_ctrl_model (
    input  wire logic       ref_clk,
    input  wire logic       selectOn,
    input  wire logic [3:0] head,
    input  wire logic       wantWrite,
    input  wire logic       wPulse,
    input  wire logic       readyN,
    input  wire logic       seek_complete_n,
    output logic            drive_select_n,
    output logic [3:0]      headSelN,
    output logic            writeGateN,
    output logic            write_pulse_pair
);
    // =======================================================
    // Pin drive
    // =======================================================
    // Idle levels at time zero
    initial begin
        drive_select_n   = 1'b1;
        headSelN         = 4'hF;
        writeGateN       = 1'b1;
        write_pulse_pair = 1'b0;
    end

    // Gate opens only on a ready drive but is held for the whole write,
    // so a mid-write loss of seek complete is really seen by the drive
    always @(posedge ref_clk) begin
        drive_select_n   <= !selectOn;
        headSelN         <= ~head;       // Active low, binary weighted
        write_pulse_pair <= wPulse;
        if (!wantWrite) begin
            writeGateN <= 1'b1;
        end else if (!readyN && !seek_complete_n) begin
            writeGateN <= 1'b0;
        end
    end
endmodule : host_ctrl_model

// file: verif/disk_rw_channel_control_bench.sv
/*
 * Self-checking bench for the read/write channel control.
 * Assumes short reset hold and self test counts set by parameter.
 */
`timescale 1ns/1ps
module disk_rw_channel_control_bench;
    import rw_channel_pkg::*;
    // =======================================================
    // Signals
    // =======================================================
    logic        ref_clk = 1'b0, rst = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rng = 32'h49;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = HSIZE_WORD, sup = 3'h7;
    logic        selectOn = 1'b0, wantWrite = 1'b0, wPulse = 1'b0;
    logic [3:0]  head = 4'h0, headSelN, r4;
    logic        dsN, wgN, wpp, rpp, wfN, readyN, scN, wco, wch, c;
    logic        unsafe = 1'b0, zc = 1'b0, curBad = 1'b0;
    logic        spin = 1'b0, offT = 1'b0;
    logic [15:0] t;
    preamp_sel_t ps;
    int          n_mismatch = 0, checks = 0, nRead = 0, n0;

    // Clock of 100 ns period
    always #50 ref_clk = ~ref_clk;

    // Count one-cycle read pulses
    always @(posedge ref_clk) if (rpp === 1'b1) nRead++;

    host_ctrl_model u_host (.ref_clk(ref_clk), .selectOn(selectOn),
        .head(head), .wantWrite(wantWrite), .wPulse(wPulse),
        .readyN(readyN), .seek_complete_n(scN), .drive_select_n(dsN),
        .headSelN(headSelN), .writeGateN(wgN), .write_pulse_pair(wpp));

    disk_rw_channel_control #(.PorHoldCycles(20), .SelfTestCycles(10))
    u_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .drive_select_n(dsN), .head_sel_bit0_n(headSelN[0]),
        .head_sel_bit1_n(headSelN[1]), .head_sel_bit2_n(headSelN[2]),
        .head_sel_bit3_n(headSelN[3]), .writeGateN(wgN),
        .write_pulse_pair(wpp), .read_pulse_pair(rpp),
        .write_fault_n(wfN), .readyN(readyN), .seek_complete_n(scN),
        .preamp_low_enable_n(ps.lowEnableN),
        .preamp_high_enable_n(ps.highEnableN), .head_bit_a(ps.bitA),
        .head_bit_b(ps.bitB), .write_enable_out(ps.writeEnable),
        .write_control_out(wco), .writeCurrentHigh(wch),
        .preamp_unsafe(unsafe), .zeroCross(zc), .supply5Ok(sup[0]),
        .supply12Ok(sup[1]), .supplyNeg10Ok(sup[2]), .spindleBad(spin),
        .offTrack(offT), .currentSourceBad(curBad), .selfTestPass(1'b0));

    // =======================================================
    // Helpers
    // =======================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Expected preamp outputs; the top head-select line never counts
    function automatic logic [31:0] expSel(input logic [3:0] h,
                                           input logic we);
        return {27'h0, h[2], !h[2], h[0], h[1], we};
    endfunction : expSel

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask : chk

    // One single AHB transfer, waiting on hready in both phases
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        r = hrdata;
    endtask : ahb

    task automatic waitReady();
        for (int i = 0; i < 300 && readyN !== 1'b0; i++) @(posedge ref_clk);
    endtask : waitReady

    task automatic waitWe();
        for (int i = 0; i < 30 && ps.writeEnable !== 1'b1; i++)
            @(posedge ref_clk);
    endtask : waitWe

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // =======================================================
    // Watchdog: whole run is well under a thousand cycles
    // =======================================================
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        results();
    end

    // =======================================================
    // Main sequence
    // =======================================================
    initial begin
        repeat (20) @(posedge ref_clk);
        chk(ps.writeEnable, 0, "we in reset");
        chk(readyN, 1, "ready in reset");
        rst <= 1'b0;
        repeat (15) @(posedge ref_clk);
        chk(readyN, 1, "ready before hold ends");
        waitReady();
        chk({readyN, scN}, 0, "ready after test");
        ahb(CTRL_ADDR, 1'b0, 32'h0, rd);
        chk(rd, CTRL_RESET, "ctrl reset");
        ahb(8'h10, 1'b0, 32'h0, rd);
        chk(rd, 0, "unmapped read");
        ahb(STATUS_ADDR, 1'b0, 32'h0, rd);
        chk(rd, 32'h20, "status ready");
        $display("test power up done");
        // All sixteen head codes in a scrambled order
        selectOn <= 1'b1;
        rng = xs(rng);
        r4 = rng[3:0];
        for (int i = 0; i < 16; i++) begin
            head <= 4'(i) ^ r4;
            repeat (6) @(posedge ref_clk);
            chk({27'h0, ps}, expSel(head, 0), "decode");
        end
        $display("test head decode done");
        for (int k = 0; k < 3; k++) begin
            sup[k] <= 1'b0;
            repeat (8) @(posedge ref_clk);
            chk({readyN, ps.writeEnable}, 2, "supply drop");
            sup[k] <= 1'b1;
            waitReady();
        end
        $display("test supplies done");
        selectOn <= 1'b0;
        wantWrite <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk(ps.writeEnable, 0, "write deselected");
        wantWrite <= 1'b0;
        selectOn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        for (int j = 0; j < 4; j++) begin
            rng = xs(rng);
            t = (j == 0) ? 16'h01FF : (j == 1) ? 16'h0200 : {6'h0, rng[9:0]};
            ahb(TRACK_ADDR, 1'b1, {16'h0, t}, rd);
            head <= rng[15:12];
            wantWrite <= 1'b1;
            waitWe();
            repeat (2) @(posedge ref_clk);
            chk({27'h0, ps}, expSel(head, 1), "write sel");
            chk(wch, t < INNER_ZONE_LIMIT, "zone");
            c = wco;
            n0 = nRead;
            for (int p = 0; p < 3; p++) begin
                wPulse <= 1'b1;
                repeat (3) @(posedge ref_clk);
                wPulse <= 1'b0;
                zc <= !zc;
                repeat (5) @(posedge ref_clk);
                chk(wco, c ^ !p[0], "toggle");
            end
            chk(nRead, n0, "read during write");
            wantWrite <= 1'b0;
            repeat (6) @(posedge ref_clk);
            chk({ps.writeEnable, wco, wch}, 0, "write off");
        end
        $display("test write done");
        for (int q = 0; q < 6; q++) begin
            n0 = nRead;
            rng = xs(rng);
            zc <= !zc;
            repeat (8 + rng[1:0]) @(posedge ref_clk);
            chk(nRead, n0 + 1, "read pulse");
            zc <= !zc;
            @(posedge ref_clk);
            zc <= !zc;
            repeat (8) @(posedge ref_clk);
            chk(nRead, n0 + 1, "glitch");
        end
        ahb(COUNT_ADDR, 1'b0, 32'h0, rd);
        chk(rd, 6, "peak count");
        $display("test read done");
        for (int f = 0; f < 4; f++) begin
            wantWrite <= 1'b1;
            waitWe();
            unsafe <= (f == 0);
            curBad <= (f == 1);
            offT <= (f == 2);
            spin <= (f == 3);
            for (int i = 0; i < 20 && wfN !== 1'b0; i++) @(posedge ref_clk);
            repeat (2) @(posedge ref_clk);
            chk({wfN, ps.writeEnable}, 0, "fault");
            if (f > 1) chk({readyN, scN}, 3, "not ready");
            {unsafe, curBad, offT, spin} <= 4'h0;
            wantWrite <= 1'b0;
            repeat (6) @(posedge ref_clk);
            ahb(CTRL_ADDR, 1'b1, 32'h3, rd);
            repeat (2) @(posedge ref_clk);
            chk(wfN, 1, "fault cleared");
            waitReady();
        end
        ahb(CTRL_ADDR, 1'b1, 32'h0, rd);                 // Four-head mode
        head <= 4'h5;
        wantWrite <= 1'b1;
        repeat (12) @(posedge ref_clk);
        chk({wfN, ps[4:3]}, 32'h1, "head beyond four");
        $display("test faults done");
        results();
    end
endmodule : disk_rw_channel_control_bench
